// ---- logic/cmp_unit.sv ----
// Compare-with-borrow and compare-and-skip execution unit.
// Assumes decode presents instr with operand values in the same cycle,
// and that fetch reports whether the prefetched instruction is 2 words.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_map.svh"

module cmp_unit
    import cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire instr_t instr,
    input wire word_t default_work_register,
    input wire word_t base_val,
    input wire word_t second_val,
    input wire word_t file_val,
    input wire logic next_two_word,
    input wire logic carry_in,
    input wire logic zero_in,
    output logic flags_we,
    output logic digit_carry_flag,
    output logic neg_flag,
    output logic signed_range_flag,
    output logic zero_flag,
    output logic carry_flag,
    output logic base_sel,
    output logic skip_nop,
    output logic ptr_we,
    output logic [3:0] ptr_idx,
    output logic [1:0] ptr_delta,
    output logic ptr_dec,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // Reset release
    logic [1:0] rst_sync_r;
    wire logic rst_n = rst_sync_r[1];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // Field helpers shared by several decoders
    function automatic logic is_opc(input instr_t i, input logic [7:0] o);
        is_opc = (i[`F_OPC] == o);
    endfunction

    function automatic logic rb_shape(input instr_t i);
        rb_shape = (i[`F_ZERO_RB] == `ZERO2);
    endfunction

    function automatic logic skip_shape(input instr_t i);
        skip_shape = rb_shape(i) && (i[`F_SKIPZ] == `ZERO4);
    endfunction

    // Control register
    logic enable_r;
    logic busy_r;

    // Decode
    wire logic take = instr_valid && enable_r && !busy_r;
    wire logic dec_f = is_opc(instr, `OPC_BORROW_F) && instr[`F_HI]
        && !instr[`F_ZERO_F];
    wire logic dec_w = is_opc(instr, `OPC_BORROW_W) && instr[`F_HI]
        && rb_shape(instr);
    wire logic dec_lit = dec_w
        && (instr[`F_LITTAG] == `LIT_TAG);
    wire logic dec_reg = dec_w && !instr[`F_MODE7]
        && (instr[`F_PPP] <= `AM_PRE_INC);
    wire logic dec_eq = is_opc(instr, `OPC_SKIP_EQ) && instr[`F_HI]
        && skip_shape(instr);
    wire logic dec_gt = is_opc(instr, `OPC_SKIP_GL) && !instr[`F_HI]
        && skip_shape(instr);
    wire logic dec_lt = is_opc(instr, `OPC_SKIP_GL) && instr[`F_HI]
        && skip_shape(instr);
    wire logic dec_borrow = dec_f || dec_lit || dec_reg;
    wire logic dec_skip = dec_eq || dec_gt || dec_lt;

    // Byte select sits at a different place in the file form
    wire logic byte_mode = dec_f ? instr[`F_BYTE_F]
        : instr[`F_BYTE_RB];

    // Operand selection
    wire word_t lit_val = {11'h0, instr[`F_LIT]};
    wire word_t op_a = dec_f ? file_val : base_val;
    wire word_t op_b = dec_f ? default_work_register
        : dec_lit ? lit_val
        : second_val;
    // Skip compares do a plain subtraction with no borrow
    wire logic cin = dec_skip ? 1'b1 : carry_in;

    wire logic s_half;
    wire logic s_n;
    wire logic s_range;
    wire logic s_z;
    wire logic s_c;

    sub_flags u_sub (
        .a(op_a),
        .b(op_b),
        .carry_in(cin),
        .byte_mode(byte_mode),
        .digit_carry(s_half),
        .neg(s_n),
        .ovf(s_range),
        .zero(s_z),
        .carry(s_c)
    );

    // Skip conditions from signed compare of the difference
    wire logic lt_signed = s_n ^ s_range;
    wire logic skip_hit = (dec_eq && s_z)
        || (dec_gt && !lt_signed && !s_z)
        || (dec_lt && lt_signed);
    wire logic skip_go = take && skip_hit;

    // Sticky zero: a zero result keeps the old flag, never sets it
    wire logic z_new = zero_in && s_z;

    // Pointer update for the pre/post increment and decrement source forms
    wire logic [2:0] am = instr[`F_PPP];
    wire logic am_upd = (am == `AM_POST_DEC) || (am == `AM_POST_INC)
        || (am == `AM_PRE_DEC) || (am == `AM_PRE_INC);
    wire logic am_dec = (am == `AM_POST_DEC) || (am == `AM_PRE_DEC);
    wire logic [1:0] step = byte_mode ? 2'h1 : 2'h2;

    // Flag outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_we <= 1'b0;
            digit_carry_flag <= 1'b0;
            neg_flag <= 1'b0;
            signed_range_flag <= 1'b0;
            zero_flag <= 1'b0;
            carry_flag <= 1'b0;
        end else begin
            // Skip compares never write the status word
            flags_we <= take && dec_borrow;
            if (take && dec_borrow) begin
                digit_carry_flag <= s_half;
                neg_flag <= s_n;
                signed_range_flag <= s_range;
                zero_flag <= z_new;
                carry_flag <= s_c;
            end
        end
    end

    // Marks that the base operand of the instruction taken last cycle came from the w field
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_sel <= 1'b0;
        end else begin
            base_sel <= take && (dec_lit || dec_reg || dec_skip);
        end
    end

    // Pointer adjust request to the register file
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_we <= 1'b0;
            ptr_idx <= 4'h0;
            ptr_delta <= 2'h0;
            ptr_dec <= 1'b0;
        end else begin
            ptr_we <= take && dec_reg && am_upd;
            ptr_idx <= instr[`F_S];
            ptr_delta <= step;
            ptr_dec <= am_dec;
        end
    end

    // Skip sequencer: one no-op per word of the discarded instruction
    skip_state_e state_r;
    skip_state_e state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (skip_go) begin
                    state_nxt = next_two_word ? ST_NOP2 : ST_NOP1;
                end
            end
            ST_NOP2: begin
                state_nxt = ST_NOP1;
            end
            ST_NOP1: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    wire logic nop_nxt = (state_nxt != ST_RUN);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RUN;
            skip_nop <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // Prefetched word is squashed while this is high
            skip_nop <= nop_nxt;
            busy_r <= nop_nxt;
        end
    end

    // Software visible state
    logic last_skip_r;
    logic [15:0] skip_count_r;
    logic [12:0] faddr_r;

    // Wishbone slave, answers one cycle after the request
    wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wb_wr = wb_req && wb_we_i;
    wire logic hit_ctrl = (wb_adr_i == `REG_CTRL);
    wire logic hit_flags = (wb_adr_i == `REG_FLAGS);
    wire logic hit_skips = (wb_adr_i == `REG_SKIPS);
    wire logic hit_faddr = (wb_adr_i == `REG_FADDR);
    wire logic wr_ctrl = wb_wr && hit_ctrl && wb_sel_i[0];
    wire logic wr_skips = wb_wr && hit_skips && (wb_sel_i[1:0] != 2'h0);
    wire logic [31:0] flags_word = {26'h0, last_skip_r, digit_carry_flag,
        neg_flag, signed_range_flag, zero_flag, carry_flag};
    wire logic [31:0] rd_mux = hit_ctrl ? {31'h0, enable_r}
        : hit_flags ? flags_word
        : hit_skips ? {16'h0, skip_count_r}
        : hit_faddr ? {19'h0, faddr_r}
        : 32'h0;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            enable_r <= 1'b1;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
            if (wr_ctrl) begin
                enable_r <= wb_dat_i[`CTRL_EN];
            end
        end
    end

    // Counter write clears; a skip in the same cycle still counts
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_count_r <= 16'h0;
            last_skip_r <= 1'b0;
            faddr_r <= 13'h0;
        end else begin
            if (skip_go) begin
                skip_count_r <= wr_skips ? 16'h1 : skip_count_r + 16'h1;
            end else if (wr_skips) begin
                skip_count_r <= 16'h0;
            end
            if (take && dec_skip) begin
                last_skip_r <= skip_hit;
            end
            if (take && dec_f) begin
                faddr_r <= instr[`F_FADDR];
            end
        end
    end
endmodule // cmp_unit
`default_nettype wire

// ---- logic/cmp_map.svh ----
// Encoding fields, opcodes, addressing codes and register offsets
// for the compare unit. Assumes a 24-bit instruction word.
`ifndef CMP_MAP_SVH
`define CMP_MAP_SVH

`define INSTR_W 24
`define DATA_W 16
`define F_OPC 23:16
`define F_HI 15
`define F_W 14:11
`define F_BYTE_RB 10
`define F_BYTE_F 14
`define F_ZERO_F 13
`define F_FADDR 12:0
`define F_ZERO_RB 9:8
`define F_MODE7 7
`define F_PPP 6:4
`define F_LITTAG 7:5
`define F_LIT 4:0
`define F_SKIPZ 7:4
`define F_S 3:0

`define OPC_BORROW_F 8'he3
`define OPC_BORROW_W 8'he1
`define OPC_SKIP_EQ 8'he7
`define OPC_SKIP_GL 8'he6
`define LIT_TAG 3'h3
`define ZERO2 2'h0
`define ZERO4 4'h0

`define AM_DIRECT 3'h0
`define AM_INDIRECT 3'h1
`define AM_POST_DEC 3'h2
`define AM_POST_INC 3'h3
`define AM_PRE_DEC 3'h4
`define AM_PRE_INC 3'h5

`define BYTE_MSB 7
`define WORD_MSB 15
`define NIB_MSB 3

`define REG_CTRL 8'h00
`define REG_FLAGS 8'h04
`define REG_SKIPS 8'h08
`define REG_FADDR 8'h0c
`define CTRL_EN 0
`define CTRL_RST 32'h0000_0001

`endif

// ---- logic/cmp_pkg.sv ----
// Types shared by the compare unit files.
// Assumes cmp_map.svh is on the include path.
`default_nettype none
`include "cmp_map.svh"
package cmp_pkg;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`INSTR_W-1:0] instr_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_NOP1 = 3'h2,
        ST_NOP2 = 3'h4
    } skip_state_e;
endpackage
`default_nettype wire

// ---- logic/sub_flags.sv ----
// Subtractor a - b - borrow with flag outputs for word or byte width.
// Purely combinational; the caller registers results.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_map.svh"
module sub_flags
    import cmp_pkg::*;
(
    input wire word_t a,
    input wire word_t b,
    input wire logic carry_in,
    input wire logic byte_mode,
    output logic digit_carry,
    output logic neg,
    output logic ovf,
    output logic zero,
    output logic carry
);
    // Carry in of one means no borrow
    wire logic [`DATA_W:0] sum = {1'b0, a} + {1'b0, ~b} + {16'h0, carry_in};
    wire word_t diff = sum[`DATA_W-1:0];
    wire logic [`NIB_MSB+1:0] nib = {1'b0, a[`NIB_MSB:0]}
        + {1'b0, ~b[`NIB_MSB:0]} + {4'h0, carry_in};
    wire logic [`BYTE_MSB+1:0] bsum = {1'b0, a[`BYTE_MSB:0]}
        + {1'b0, ~b[`BYTE_MSB:0]} + {8'h0, carry_in};
    wire logic rng_b = (a[`BYTE_MSB] ^ b[`BYTE_MSB])
        & (a[`BYTE_MSB] ^ diff[`BYTE_MSB]);
    wire logic rng_w = (a[`WORD_MSB] ^ b[`WORD_MSB])
        & (a[`WORD_MSB] ^ diff[`WORD_MSB]);

    assign digit_carry = nib[`NIB_MSB+1];
    // Byte mode looks at bit 7 and the low byte only
    assign neg = byte_mode ? diff[`BYTE_MSB] : diff[`WORD_MSB];
    assign ovf = byte_mode ? rng_b : rng_w;
    assign carry = byte_mode ? bsum[`BYTE_MSB+1] : sum[`DATA_W];
    assign zero = byte_mode ? (diff[`BYTE_MSB:0] == 8'h00)
        : (diff == 16'h0000);
endmodule // sub_flags
`default_nettype wire

// ---- sim/cmp_chk.sv ----
// Port-level checks on the compare unit.
// Bound to cmp_unit from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module cmp_chk
    import cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire instr_t instr,
    input wire word_t base_val,
    input wire word_t second_val,
    input wire logic next_two_word,
    input wire logic zero_in,
    input wire logic flags_we,
    input wire logic neg_flag,
    input wire logic zero_flag,
    input wire logic carry_flag,
    input wire logic skip_nop,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Opcodes e6 and e7 share their top seven bits
    wire skip_op = instr_valid && !skip_nop && instr[23:17] == 7'h73;
    flag_hold_a: assert property (!flags_we |->
        $stable({neg_flag, zero_flag, carry_flag})) else $error("flags moved");
    zero_sticky_a: assert property (flags_we && !$past(zero_in) |->
        !zero_flag) else $error("zero flag was set");
    skip_noflag_a: assert property (skip_op |=> !flags_we)
        else $error("skip compare wrote flags");
    nop_max_a: assert property (skip_nop ##1 skip_nop |=> !skip_nop)
        else $error("squash longer than two cycles");
    two_word_a: assert property ($rose(skip_nop) |=>
        skip_nop == $past(next_two_word, 2)) else $error("squash length");
    skip_cause_a: assert property ($rose(skip_nop) |-> $past(skip_op))
        else $error("squash without skip compare");
    equal_skip_a: assert property (skip_op && instr[16:15] == 2'h3 &&
        instr[10:4] == 7'h00 |=> skip_nop == $past(base_val == second_val))
        else $error("equal skip decision");
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("bus ack late");
endmodule // cmp_chk
`default_nettype wire

// ---- sim/fetch_rf_model.sv ----
// Working registers and operand fetch facing the compare unit.
// Pre-modified addresses are not applied; the bench keeps neighbours equal.
`timescale 1ns/100ps
`default_nettype none
module fetch_rf_model
    import cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire instr_t instr,
    input wire logic ptr_we,
    input wire logic [3:0] ptr_idx,
    input wire logic [1:0] ptr_delta,
    input wire logic ptr_dec,
    output word_t default_work_register,
    output word_t base_val,
    output word_t second_val,
    output word_t file_val
);
    word_t regs [16];
    word_t mem [16];
    wire [3:0] src = instr[3:0];
    wire word_t step = {14'h0000, ptr_delta};
    wire direct = instr[6:4] == 3'h0 || instr[23:16] != 8'he1;
    assign default_work_register = regs[0];
    assign base_val = regs[instr[14:11]];
    assign second_val = direct ? regs[src] : mem[regs[src][3:0]];
    assign file_val = mem[instr[3:0]];
    always @(posedge ref_clk) begin
        if (ptr_we)
            regs[ptr_idx] <= ptr_dec ? regs[ptr_idx] - step :
                regs[ptr_idx] + step;
    end
endmodule // fetch_rf_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the compare unit and its fetch partner.
// Assumes design sources, cmp_chk and fetch_rf_model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_map.svh"
module tb_top
    import cmp_pkg::*;
;
    logic ref_clk = 0, reset_n = 0, instr_valid = 0, next_two_word = 0;
    logic carry_in = 0, zero_in = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic wb_we_i = 0, flags_we, digit_carry_flag, neg_flag, zero_flag;
    logic signed_range_flag, carry_flag, base_sel, skip_nop, ptr_we;
    logic ptr_dec, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf, ptr_idx, skw = 4'h1;
    logic [1:0] ptr_delta;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    instr_t instr = 24'h0;
    word_t default_work_register, base_val, second_val, file_val;
    int num_errors = 0, n_tests = 0;
    wire [4:0] flg = {digit_carry_flag, neg_flag, signed_range_flag,
        zero_flag, carry_flag};
    always #5 ref_clk = ~ref_clk;
    cmp_unit dut (.*);
    fetch_rf_model rf (.*);
    task chk(string n, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Borrow semantics: carry set means no borrow, as for C
    function logic [4:0] fx(word_t a, word_t b, logic c, logic z, logic bm);
        logic [16:0] m, s;
        logic [4:0] d;
        int w;
        w = bm ? 8 : 16;
        m = bm ? 17'h000ff : 17'h0ffff;
        s = ({1'b0, a} & m) + ({1'b0, ~b} & m) + c;
        d = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + c;
        return {d[4], s[w-1], a[w-1] != b[w-1] && s[w-1] != a[w-1],
            z && (s & m) == 17'h0, s[w]};
    endfunction
    function instr_t rg(logic [3:0] w, logic bm, logic [2:0] p, logic [3:0] s);
        return {8'he1, 1'b1, w, bm, 3'h0, p, s};
    endfunction
    task bus_op(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Ack and read data are taken at the edge that samples ack high
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task rd(string n, logic [7:0] a, logic [31:0] e);
        bus_op(0, a, 32'h0);
        chk(n, rdat, e);
    endtask
    task iss(instr_t i, logic c, logic z);
        @(posedge ref_clk);
        instr_valid <= 1;
        instr <= i;
        carry_in <= c;
        zero_in <= z;
        @(posedge ref_clk);
        instr_valid <= 0;
        #1;
    endtask
    task bc(instr_t i, word_t a, word_t b, logic c, logic z);
        logic bm;
        bm = i[23:16] == `OPC_BORROW_F ? i[`F_BYTE_F] : i[`F_BYTE_RB];
        iss(i, c, z);
        chk("flags_we", flags_we, 1);
        chk("base_sel", base_sel, i[23:16] == `OPC_BORROW_W);
        chk("flags", flg, fx(a, b, c, z, bm));
    endtask
    task sk(logic [7:0] o, logic h, logic bm, word_t a, word_t b,
        logic tk, logic two);
        logic [4:0] f0;
        f0 = flg;
        rf.regs[skw] = a;
        rf.regs[skw + 4'h8] = b;
        @(posedge ref_clk);
        instr_valid <= 1;
        instr <= {o, h, skw, bm, 6'h00, skw + 4'h8};
        next_two_word <= two;
        @(posedge ref_clk);
        // The prefetched word is offered only when the skip is taken, and must be dropped
        instr_valid <= tk;
        instr <= rg(4'h1, 0, 3'h0, 4'h2);
        #1 chk("skip_nop1", skip_nop, tk);
        @(posedge ref_clk);
        instr_valid <= 0;
        #1 chk("skip_nop2", skip_nop, tk & two);
        chk("flags_we", flags_we, 0);
        @(posedge ref_clk);
        #1 chk("skip_nop3", skip_nop, 0);
        chk("flags", flg, f0);
        skw++;
    endtask
    task t_bus;
        rd("ctrl", `REG_CTRL, `CTRL_RST);
        rd("flags", `REG_FLAGS, 32'h0);
        rd("skips", `REG_SKIPS, 32'h0);
        rd("unmapped", 8'h10, 32'h0);
        bus_op(1, 8'h10, 32'h0);
        bus_op(1, `REG_CTRL, 32'h0);
        iss(rg(4'h1, 0, 3'h0, 4'h2), 1, 0);
        chk("disabled", flags_we, 0);
        bus_op(1, `REG_CTRL, 32'h1);
        rd("ctrl", `REG_CTRL, 32'h1);
        $display("test bus done");
    endtask
    task t_borrow;
        rf.regs[0] = 16'h8823;
        rf.mem[0] = 16'h0823;
        bc({8'he3, 3'h6, 13'h0400}, 16'h0823, 16'h8823, 0, 0);
        rf.regs[0] = 16'h2377;
        rf.mem[15] = 16'h2377;
        bc({8'he3, 3'h4, 13'h1fff}, 16'h2377, 16'h2377, 1, 0);
        rd("file_addr", `REG_FADDR, 32'h1fff);
        rf.regs[12] = 16'h0020;
        bc({8'he1, 1'b1, 4'hc, 6'h03, 5'h1f}, 16'h20, 16'h1f, 0, 1);
        rf.regs[4] = 16'h7711;
        bc({8'he1, 1'b1, 4'h4, 6'h23, 5'h12}, 16'h7711, 16'h12, 1, 0);
        rf.regs[4] = 16'h4000;
        rf.regs[5] = 16'h3000;
        bc(rg(4'h4, 0, 3'h0, 4'h5), 16'h4000, 16'h3000, 1, 0);
        chk("ptr_we", ptr_we, 0);
        rf.regs[0] = 16'haba9;
        rf.regs[1] = 16'h1000;
        rf.mem[0] = 16'hd0a9;
        bc(rg(4'h0, 1, 3'h3, 4'h1), 16'haba9, 16'hd0a9, 0, 1);
        chk("ptr", {ptr_we, ptr_idx, ptr_delta, ptr_dec}, 8'h8a);
        @(posedge ref_clk);
        #1 chk("ptr_reg", rf.regs[1], 16'h1001);
        rf.regs[3] = 16'h0005;
        rf.regs[2] = 16'h1004;
        rf.mem[2] = 16'h0005;
        rf.mem[4] = 16'h0005;
        bc(rg(4'h3, 0, 3'h4, 4'h2), 16'h0005, 16'h0005, 1, 0);
        chk("ptr", {ptr_we, ptr_idx, ptr_delta, ptr_dec}, 8'h95);
        $display("test borrow done");
    endtask
    task t_skip;
        sk(8'he7, 1, 0, 16'h3344, 16'h3344, 1, 1);
        sk(8'he7, 1, 0, 16'h3344, 16'h3345, 0, 0);
        sk(8'he6, 0, 1, 16'h00ff, 16'h26fe, 1, 0);
        sk(8'he6, 0, 0, 16'h4000, 16'h4000, 0, 1);
        sk(8'he6, 1, 1, 16'h00ff, 16'h26fe, 0, 0);
        sk(8'he6, 1, 0, 16'h2600, 16'h3000, 1, 1);
        // Last borrow compare left DC and C set; the last skip was taken
        rd("flags_reg", `REG_FLAGS, 32'h31);
        rd("skips", `REG_SKIPS, 32'h3);
        bus_op(1, `REG_SKIPS, 32'h1);
        rd("skips_clr", `REG_SKIPS, 32'h0);
        $display("test skip done");
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1;
        repeat (3) @(posedge ref_clk);
        t_bus;
        t_borrow;
        t_skip;
        wrap_up;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        wrap_up;
    end
endmodule // tb_top
bind cmp_unit cmp_chk chk_i (.*);
`default_nettype wire
